// >>> pie_pkg.sv
/*
 * Package for the peripheral interrupt enable and priority block:
 * register offsets, bit positions, reset values and state types.
 * Assumes a 32-bit APB register bus; each register is one aligned word.
 */
package pie_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int REG_W = 8;

    // Byte offsets of the register map
    localparam logic [AW-1:0] OFF_ENABLE3 = 8'h00;
    localparam logic [AW-1:0] OFF_PRIO1 = 8'h04;
    localparam logic [AW-1:0] OFF_RESET_STATUS = 8'h08;
    localparam logic [AW-1:0] OFF_REQ_RAW = 8'h0c;
    localparam logic [AW-1:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [AW-1:0] OFF_IRQ_ENABLE = 8'h14;
    localparam logic [AW-1:0] OFF_IRQ_CLEAR = 8'h18;
    localparam logic [AW-1:0] OFF_MODE = 8'h1c;

    // Third enable register fields
    localparam int EN_CAPCOMP3 = 0;
    localparam int EN_CAPCOMP4 = 1;
    localparam int EN_CAPCOMP5 = 2;
    localparam int EN_TIMER4 = 3;
    localparam int EN_UART2_TX = 4;
    localparam int EN_UART2_RX = 5;
    localparam int EN_SRC_N = 6;
    localparam logic [REG_W-1:0] ENABLE3_MASK = 8'h3f;
    localparam logic [REG_W-1:0] ENABLE3_RST = 8'h00;

    // First priority register: bit 7 is the parallel slave port
    localparam int PRIO_SRC_N = 8;
    localparam int PRIO_PAR_PORT = 7;
    localparam logic [REG_W-1:0] PRIO1_RST = 8'hff;

    // Reset-status register: priority enable in bit 7
    localparam int RSTAT_PRIO_EN = 7;
    localparam logic [REG_W-1:0] RSTAT_RW_MASK = 8'h80;

    // Mode register: bit 0 selects microcontroller mode
    localparam int MODE_MCU = 0;

    // Interrupt status layout
    localparam int IS_HIGH = 0;
    localparam int IS_LOW = 1;
    localparam int IS_BAD_ADDR = 2;
    localparam int IS_N = 3;

    typedef enum logic [1:0] {
        PIE_LVL_NONE,
        PIE_LVL_LOW,
        PIE_LVL_HIGH
    } pie_level_t;

    typedef enum logic {
        PIE_BUS_IDLE,
        PIE_BUS_DONE
    } pie_bus_t;
endpackage : pie_pkg

// >>> pie_prio_route.sv
/*
 * Combinational router: gated requests go to the high or low level.
 * Assumes requests are already enable-gated and on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pie_prio_route (
    input wire logic [pie_pkg::PRIO_SRC_N-1:0] reqIn,  // Gated requests
    input wire logic [pie_pkg::PRIO_SRC_N-1:0] prioIn, // 1 = high
    input wire logic prioEn,                           // Two-level mode
    output logic toHigh,                               // Any to high
    output logic toLow                                 // Any to low
);
    import pie_pkg::*;
    logic [PRIO_SRC_N-1:0] hiVec;
    logic [PRIO_SRC_N-1:0] loVec;

    genvar g;
    generate
        for (g = 0; g < PRIO_SRC_N; g++) begin : gRoute
            // Compatibility mode sends every request to the high level
            assign hiVec[g] = reqIn[g] & (~prioEn | prioIn[g]);
            assign loVec[g] = reqIn[g] & prioEn & ~prioIn[g];
        end
    endgenerate

    assign toHigh = |hiVec;
    assign toLow = |loVec;
endmodule : pie_prio_route
`default_nettype wire

// >>> pie_regs.sv
/*
 * Peripheral interrupt enable/priority block with APB slave.
 * Assumes request inputs come from pins or other domains and are
 * synchronised here; APB is on ref_clk, and writes take effect on
 * the edge that ends the access.
 */
// Notes on behaviour
// - UART2 receive passes only when enabled.
// - UART2 transmit gated by its enable bit.
// - Timer-4 period match gated by enable.
// - Capture/compare 3,4,5 each own enable.
// - Priority bits held, one per source; the enable-3 sources have none here and always go to the high level.
// - Priority ignored unless global enable set.
// - Priority bit 1 high, 0 low.
// - Parallel port priority only in microcontroller mode.
// - Global priority enable is status bit 7.
`timescale 1ns/1ps
`default_nettype none
module pie_regs (
    input wire logic ref_clk,                        // 100 MHz clock
    input wire logic srst,                           // Sync reset, high
    input wire logic psel,                           // APB select
    input wire logic penable,                        // APB enable
    input wire logic pwrite,                         // APB write
    input wire logic [pie_pkg::AW-1:0] paddr,        // APB byte address
    input wire logic [pie_pkg::DW-1:0] pwdata,       // APB write data
    output logic [pie_pkg::DW-1:0] prdata,           // APB read data
    output logic pready,                             // APB ready
    output logic pslverr,                            // APB error
    input wire logic [pie_pkg::EN_SRC_N-1:0] reqGrp3, // Enable-3 sources
    input wire logic [pie_pkg::PRIO_SRC_N-1:0] reqGrp1, // Prio-1 sources
    output logic [pie_pkg::EN_SRC_N-1:0] reqGated3,  // Gated requests
    output logic cpuIrqHigh,                         // High level request
    output logic cpuIrqLow,                          // Low level request
    output logic irq                                 // Summary interrupt
);
    import pie_pkg::*;

    logic [EN_SRC_N-1:0] req3M_r, req3S_r, req3M_nxt, req3S_nxt;
    logic [PRIO_SRC_N-1:0] req1M_r, req1S_r, req1M_nxt, req1S_nxt;
    logic [REG_W-1:0] enable3_r, enable3_nxt;
    logic [REG_W-1:0] prio1_r, prio1_nxt;
    logic [REG_W-1:0] rstat_r, rstat_nxt;
    logic [REG_W-1:0] mode_r, mode_nxt;
    logic [IS_N-1:0] isStat_r, isStat_nxt;
    logic [IS_N-1:0] isEn_r, isEn_nxt;
    logic [DW-1:0] prdata_r, prdata_nxt;
    logic [1:0] lvl_r, lvl_nxt;
    logic cpuHigh_r, cpuLow_r, cpuHigh_nxt, cpuLow_nxt;
    pie_bus_t busSt_r, busSt_nxt;

    logic setup;
    logic wrAcc;
    logic rdAcc;
    logic hit;
    logic [PRIO_SRC_N-1:0] prioEff;
    logic [PRIO_SRC_N-1:0] req1Gated;
    logic toHigh;
    logic toLow;
    logic [IS_N-1:0] evt;
    logic [IS_N-1:0] clr;
    logic wrEnable3;
    logic wrPrio1;
    logic wrRstat;
    logic wrMode;
    logic wrIsEn;
    logic wrClr;
    logic [DW-1:0] rdWord;
    logic errFlag_r;
    logic errFlag_nxt;

    function automatic logic addrKnown(input logic [AW-1:0] a);
        addrKnown = (a == OFF_ENABLE3) || (a == OFF_PRIO1) ||
                    (a == OFF_RESET_STATUS) || (a == OFF_REQ_RAW) ||
                    (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_ENABLE) ||
                    (a == OFF_IRQ_CLEAR) || (a == OFF_MODE);
    endfunction : addrKnown

    // Write strobe for one register: only on the edge that ends the access
    function automatic logic wrSel(input logic acc,
                                   input logic [AW-1:0] a,
                                   input logic [AW-1:0] off);
        wrSel = acc && (a == off);
    endfunction : wrSel

    // Two flops per request; only the second stage is read by logic
    always_comb begin
        req3M_nxt = reqGrp3;
        req3S_nxt = req3M_r;
        req1M_nxt = reqGrp1;
        req1S_nxt = req1M_r;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req3M_r <= '0;
            req3S_r <= '0;
            req1M_r <= '0;
            req1S_r <= '0;
        end else begin
            req3M_r <= req3M_nxt;
            req3S_r <= req3S_nxt;
            req1M_r <= req1M_nxt;
            req1S_r <= req1S_nxt;
        end
    end

    // Request gating and routing
    genvar g;
    generate
        for (g = 0; g < EN_SRC_N; g++) begin : gGate
            assign reqGated3[g] = req3S_r[g] & enable3_r[g];
        end
    endgenerate

    // Outside microcontroller mode the parallel-port request is masked and its priority held at high
    always_comb begin
        prioEff = prio1_r;
        if (!mode_r[MODE_MCU]) begin
            prioEff[PRIO_PAR_PORT] = 1'b1;
        end
        req1Gated = req1S_r;
        if (!mode_r[MODE_MCU]) begin
            req1Gated[PRIO_PAR_PORT] = 1'b0;
        end
    end

    pie_prio_route uRoute (
        .reqIn(req1Gated),
        .prioIn(prioEff),
        .prioEn(rstat_r[RSTAT_PRIO_EN]),
        .toHigh(toHigh),
        .toLow(toLow)
    );

    // The third-group sources carry no priority bit in this block, so they
    // join the high level; their own priority register lives elsewhere.
    always_comb begin
        cpuHigh_nxt = toHigh | (|reqGated3);
        cpuLow_nxt = toLow;
        lvl_nxt = cpuHigh_nxt ? 2'(PIE_LVL_HIGH) :
                  (cpuLow_nxt ? 2'(PIE_LVL_LOW) : 2'(PIE_LVL_NONE));
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cpuHigh_r <= 1'b0;
            cpuLow_r <= 1'b0;
            lvl_r <= '0;
        end else begin
            cpuHigh_r <= cpuHigh_nxt;
            cpuLow_r <= cpuLow_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign cpuIrqHigh = cpuHigh_r;
    assign cpuIrqLow = cpuLow_r;

    // APB: one wait state. The request is taken at the first access edge,
    // where read data is registered; pready follows one cycle later.
    // Writes land on the edge at which pready is sampled high, so a
    // master that gives up before then stores nothing, though an unmapped address still sets its bad-address status bit.
    assign setup = psel & penable & (busSt_r == PIE_BUS_IDLE);
    assign hit = addrKnown(paddr);
    assign rdAcc = setup & ~pwrite;
    assign wrAcc = psel & penable & pwrite & hit & pready;

    // Per-register write strobes
    assign wrEnable3 = wrSel(wrAcc, paddr, OFF_ENABLE3);
    assign wrPrio1 = wrSel(wrAcc, paddr, OFF_PRIO1);
    assign wrRstat = wrSel(wrAcc, paddr, OFF_RESET_STATUS);
    assign wrMode = wrSel(wrAcc, paddr, OFF_MODE);
    assign wrIsEn = wrSel(wrAcc, paddr, OFF_IRQ_ENABLE);
    assign wrClr = wrSel(wrAcc, paddr, OFF_IRQ_CLEAR);

    // Events: a rising level on each output, or a bad address
    assign evt[IS_HIGH] = cpuHigh_nxt & ~cpuHigh_r;
    assign evt[IS_LOW] = cpuLow_nxt & ~cpuLow_r;
    assign evt[IS_BAD_ADDR] = setup & ~hit;
    assign clr = wrClr ? pwdata[IS_N-1:0] : '0;

    // Bus state: idle until taken, then one cycle with pready high
    always_comb begin
        busSt_nxt = busSt_r;
        case (busSt_r)
            PIE_BUS_IDLE: begin
                if (setup) begin
                    busSt_nxt = PIE_BUS_DONE;
                end
            end
            PIE_BUS_DONE: busSt_nxt = PIE_BUS_IDLE;
            default: busSt_nxt = PIE_BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busSt_r <= PIE_BUS_IDLE;
        end else begin
            busSt_r <= busSt_nxt;
        end
    end

    // Third enable register; the two top bits are never stored
    always_comb begin
        enable3_nxt = enable3_r;
        if (wrEnable3) begin
            enable3_nxt = pwdata[REG_W-1:0] & ENABLE3_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enable3_r <= ENABLE3_RST;
        end else begin
            enable3_r <= enable3_nxt;
        end
    end

    // First priority register, one bit per source
    always_comb begin
        prio1_nxt = prio1_r;
        if (wrPrio1) begin
            prio1_nxt = pwdata[REG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prio1_r <= PRIO1_RST;
        end else begin
            prio1_r <= prio1_nxt;
        end
    end

    // Reset-status register: only the priority enable is held here; the
    // reset-cause flags belong to the reset logic and read as zero
    always_comb begin
        rstat_nxt = rstat_r;
        if (wrRstat) begin
            rstat_nxt = pwdata[REG_W-1:0] & RSTAT_RW_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rstat_r <= '0;
        end else begin
            rstat_r <= rstat_nxt;
        end
    end

    // Mode register: only the microcontroller-mode bit is stored
    always_comb begin
        mode_nxt = mode_r;
        if (wrMode) begin
            mode_nxt = '0;
            mode_nxt[MODE_MCU] = pwdata[MODE_MCU];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_r <= '0;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Interrupt status and enable; a set in the clearing cycle wins
    always_comb begin
        isStat_nxt = (isStat_r & ~clr) | evt;
        isEn_nxt = isEn_r;
        if (wrIsEn) begin
            isEn_nxt = pwdata[IS_N-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            isStat_r <= '0;
            isEn_r <= '0;
        end else begin
            isStat_r <= isStat_nxt;
            isEn_r <= isEn_nxt;
        end
    end

    // Read mux; unmapped and write-only offsets read as zero
    always_comb begin
        case (paddr)
            OFF_ENABLE3: rdWord = DW'(enable3_r & ENABLE3_MASK);
            OFF_PRIO1: rdWord = DW'(prio1_r);
            OFF_RESET_STATUS: rdWord = DW'(rstat_r);
            OFF_REQ_RAW: rdWord = DW'({req1S_r, 2'h0, req3S_r});
            OFF_IRQ_STATUS: rdWord = DW'({lvl_r, 3'h0, isStat_r});
            OFF_IRQ_ENABLE: rdWord = DW'(isEn_r);
            OFF_MODE: rdWord = DW'(mode_r);
            default: rdWord = '0;
        endcase
    end

    // Read data is captured when the request is taken and holds until the
    // next transfer, so it is settled through the cycle with pready high
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = rdAcc ? rdWord : '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata_r <= '0;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // Error flag for the transfer in flight; pslverr shows it with pready
    always_comb begin
        errFlag_nxt = errFlag_r;
        if (setup) begin
            errFlag_nxt = ~hit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            errFlag_r <= 1'b0;
        end else begin
            errFlag_r <= errFlag_nxt;
        end
    end

    assign pready = (busSt_r == PIE_BUS_DONE);
    assign pslverr = pready & errFlag_r;
    assign prdata = prdata_r;
    assign irq = |(isStat_r & isEn_r);
endmodule : pie_regs
`default_nettype wire

// >>> pie_regs_checker.sv
/* Checker for pie_regs: gating, routing, reset, APB timing.
   Bound to pie_regs; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module pie_regs_checker (
    input wire logic ref_clk, // Clock
    input wire logic srst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [pie_pkg::AW-1:0] paddr, // Address
    input wire logic [pie_pkg::DW-1:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [pie_pkg::EN_SRC_N-1:0] reqGrp3, // Raw 3
    input wire logic [pie_pkg::PRIO_SRC_N-1:0] reqGrp1, // Raw 1
    input wire logic [pie_pkg::EN_SRC_N-1:0] reqGated3, // Gated
    input wire logic cpuIrqLow // Low level
);
    import pie_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_rx_gate: assert property (reqGated3[5] |-> $past(reqGrp3[5], 2))
        else $error("rx gate");
    a_tx_gate: assert property (reqGated3[4] |-> $past(reqGrp3[4], 2))
        else $error("tx gate");
    a_match_gate: assert property (reqGated3[3] |-> $past(reqGrp3[3], 2))
        else $error("match gate");
    a_capcomp_gate: assert property (
        (reqGated3[2:0] & ~$past(reqGrp3[2:0], 2)) == 3'h0)
        else $error("capcomp gate");
    a_low_cause: assert property (cpuIrqLow |-> $past(reqGrp1, 3) != 0)
        else $error("low level");
    a_reset_quiet: assert property ($fell(srst) |->
        (reqGated3 == 6'h00 && !cpuIrqLow) [*3])
        else $error("reset state");
    a_top_zero: assert property (
        pready && !pwrite && paddr == OFF_ENABLE3 |-> prdata[31:6] == 0)
        else $error("top bits");
    a_ready_time: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready long");
    a_err_unmapped: assert property (pready && paddr > OFF_MODE |-> pslverr)
        else $error("no slverr");
    c_err: cover property (pready && pslverr);
    c_low: cover property (cpuIrqLow);
    c_gate: cover property (reqGated3[5]);
endmodule : pie_regs_checker
bind pie_regs pie_regs_checker i_pie_regs_checker (.ref_clk, .srst, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .reqGrp3,
    .reqGrp1, .reqGated3, .cpuIrqLow);
`default_nettype wire

// >>> tb.sv
/* Self-checking bench for pie_regs over APB.
   Assumes the pie_regs_checker bind is compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pie_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [DW-1:0] pwdata = '0, prdata, q;
    logic pready, pslverr, e, cpuIrqHigh, cpuIrqLow, irq;
    logic [EN_SRC_N-1:0] reqGrp3 = '0, reqGated3;
    logic [PRIO_SRC_N-1:0] reqGrp1 = '0;
    int errCount = 0, numChecks = 0;
    always #5 ref_clk = ~ref_clk;
    pie_regs i_pie_regs (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .reqGrp3, .reqGrp1, .reqGated3,
        .cpuIrqHigh, .cpuIrqLow, .irq);
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        numChecks++;
        if (s !== x) begin
            errCount++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask : chk
    // Idle edge after each transfer so psel is never assigned twice
    task apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task rdc(input logic [AW-1:0] a, input logic [31:0] m, logic [31:0] x);
        apb(1'b0, a, '0);
        chk($sformatf("reg %h", a), q & m, x);
        chk($sformatf("slverr %h", a), 32'(e), 32'h0);
    endtask : rdc
    // Outputs lag the raw requests by three clocks
    task lvl(input logic [1:0] x);
        repeat (4) @(posedge ref_clk);
        chk("level", 32'({cpuIrqHigh, cpuIrqLow}), 32'(x));
    endtask : lvl
    task t_reset;
        rdc(OFF_ENABLE3, 32'hffffffff, 32'h0);
        rdc(OFF_PRIO1, 32'hffffffff, 32'hff);
        rdc(OFF_RESET_STATUS, 32'h80, 32'h0);
    endtask : t_reset
    task t_gate;
        reqGrp3 <= 6'h3f;
        for (int i = 0; i < EN_SRC_N; i++) begin
            apb(1'b1, OFF_ENABLE3, 32'h1 << i);
            repeat (3) @(posedge ref_clk);
            chk("gated", 32'(reqGated3), 32'h1 << i);
            chk("high", 32'(cpuIrqHigh), 32'h1);
        end
        apb(1'b1, OFF_ENABLE3, 32'hff);
        rdc(OFF_ENABLE3, 32'hffffffff, 32'h3f);
        reqGrp3 <= 6'h0;
        apb(1'b1, OFF_ENABLE3, 32'h0);
    endtask : t_gate
    task t_prio;
        reqGrp1 <= 8'h02;
        apb(1'b1, OFF_PRIO1, 32'h0);
        lvl(2'b10);
        apb(1'b1, OFF_RESET_STATUS, 32'h80);
        lvl(2'b01);
        apb(1'b1, OFF_PRIO1, 32'h02);
        lvl(2'b10);
        rdc(OFF_PRIO1, 32'hff, 32'h02);
        apb(1'b1, OFF_PRIO1, 32'h0);
        reqGrp1 <= 8'h80;
        lvl(2'b00);
        rdc(OFF_REQ_RAW, 32'hffff, 32'h8000);
        apb(1'b1, OFF_MODE, 32'h1);
        lvl(2'b01);
        rdc(OFF_IRQ_STATUS, 32'hc0, 32'h40);
        rdc(OFF_MODE, 32'hff, 32'h1);
        reqGrp1 <= 8'h0;
    endtask : t_prio
    task t_irq;
        apb(1'b0, 8'h20, '0);
        chk("slverr", 32'(e), 32'h1);
        chk("bad read", q, 32'h0);
        apb(1'b1, 8'h20, 32'hff);
        chk("slverr wr", 32'(e), 32'h1);
        rdc(OFF_IRQ_STATUS, 32'h4, 32'h4);
        rdc(OFF_IRQ_STATUS, 32'h3, 32'h3);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h4);
        rdc(OFF_IRQ_ENABLE, 32'h7, 32'h4);
        chk("irq on", 32'(irq), 32'h1);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h4);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h4);
        rdc(OFF_IRQ_STATUS, 32'h4, 32'h0);
        chk("irq cleared", 32'(irq), 32'h0);
    endtask : t_irq
    task end_of_test;
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_gate();
        t_prio();
        t_irq();
        end_of_test();
    end
    // Whole run needs well under a thousand clocks
    initial begin
        repeat (3000) @(posedge ref_clk);
        errCount++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
